// ==== include/rrx_cfg.svh ====
// constants for the return and rotate execution block
`ifndef RRX_CFG_SVH
`define RRX_CFG_SVH
`define RRX_LITRET_MASK  14'h3C00
`define RRX_LITRET_MATCH 14'h3400
`define RRX_RETURN_WORD  14'h0008
`define RRX_ROT_MASK     14'h3F00
`define RRX_ROT_MATCH    14'h0C00
`define RRX_DEST_BIT     7
`define RRX_LIT_MSB      7
`define RRX_ADDR_MSB     6
`define RRX_FLUSH_CYC    2'h1
`endif

// ==== include/rrx_pkg.sv ====
// types for the return and rotate execution block
package rrx_pkg;
  typedef enum logic [1:0] {
    RRX_OP_NONE   = 2'b00,
    RRX_OP_LITRET = 2'b01,
    RRX_OP_RETURN = 2'b10,
    RRX_OP_ROTATE = 2'b11
  } rrx_op_t;
  typedef enum logic [0:0] {
    RRX_ST_EXEC  = 1'b0,
    RRX_ST_FLUSH = 1'b1
  } rrx_state_t;
endpackage

// ==== rtl/rrx_decode.sv ====
// opcode classifier for literal return, return and rotate right
`timescale 1ns/1ps
`default_nettype none
`include "rrx_cfg.svh"
module rrx_decode (
  input  wire logic [13:0]       insn,
  output var rrx_pkg::rrx_op_t   op
);
  always_comb begin
    if ((insn & `RRX_LITRET_MASK) == `RRX_LITRET_MATCH) begin
      op = rrx_pkg::RRX_OP_LITRET;
    end else if (insn == `RRX_RETURN_WORD) begin
      op = rrx_pkg::RRX_OP_RETURN;
    end else if ((insn & `RRX_ROT_MASK) == `RRX_ROT_MATCH) begin
      op = rrx_pkg::RRX_OP_ROTATE;
    end else begin
      op = rrx_pkg::RRX_OP_NONE;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/rrx_exec.sv ====
// execution of literal return, subroutine return and rotate right
// ------------------------------------------------------------------
// Functional notes
// - a literal return places its eight-bit literal in the accumulator.
// - a literal return reloads the program counter from the stack top.
// - a literal return is one word, two cycles, and leaves flags alone.
// - a plain return pops the stack into the program counter, flags kept.
// - a plain return takes two cycles before the return target runs.
// - rotate right moves carry into bit 7 and bit 0 into carry, one cycle.
// - with destination bit zero the result goes to the accumulator only.
// - with destination bit one the result goes back to the file register.
`timescale 1ns/1ps
`default_nettype none
`include "rrx_cfg.svh"
module rrx_exec #(
  parameter int PC_W = 13
) (
  input  wire logic            mclk,
  input  wire logic            sys_rst,
  input  wire logic            insn_valid,
  input  wire logic [13:0]     insn,
  input  wire logic [PC_W-1:0] stack_top_entry,
  input  wire logic [7:0]      file_rdata,
  input  wire logic            carry_in,
  output logic                 acc_we,
  output logic [7:0]           acc_wdata,
  output logic                 file_we,
  output logic [6:0]           file_waddr,
  output logic [7:0]           file_wdata,
  output logic                 carry_we,
  output logic                 carry_out,
  output logic                 pc_load,
  output logic [PC_W-1:0]      pc_value,
  output logic                 stack_pop,
  output logic                 fetch_flush,
  output logic                 busy
);
  // every check below runs on the core clock and sleeps through reset
  default clocking rrx_cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  rrx_pkg::rrx_op_t op;
  rrx_decode u_dec (
    .insn (insn),
    .op   (op)
  );

  wire logic [6:0] file_addr = insn[`RRX_ADDR_MSB:0];
  wire logic       dest_file = insn[`RRX_DEST_BIT];
  wire logic [7:0] rot_res   = {carry_in, file_rdata[7:1]};

  // ------------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------------
  rrx_pkg::rrx_state_t state, next_state;
  logic next_acc_we, next_file_we, next_carry_we, next_carry_out;
  logic next_pc_load, next_stack_pop, next_fetch_flush, next_busy;
  logic [7:0]      next_acc_wdata, next_file_wdata;
  logic [6:0]      next_file_waddr;
  logic [PC_W-1:0] next_pc_value;

  // returns spend their second cycle here while the stale fetch is discarded
  always_comb begin
    next_state       = state;
    next_acc_we      = 1'b0;
    next_acc_wdata   = acc_wdata;
    next_file_we     = 1'b0;
    next_file_waddr  = file_waddr;
    next_file_wdata  = file_wdata;
    next_carry_we    = 1'b0;
    next_carry_out   = carry_out;
    next_pc_load     = 1'b0;
    next_pc_value    = pc_value;
    next_stack_pop   = 1'b0;
    next_fetch_flush = 1'b0;
    next_busy        = 1'b0;
    unique case (state)
      rrx_pkg::RRX_ST_EXEC: begin
        if (insn_valid) begin
          unique case (op)
            rrx_pkg::RRX_OP_LITRET: begin
              next_acc_we      = 1'b1;
              next_acc_wdata   = insn[`RRX_LIT_MSB:0];
              next_pc_load     = 1'b1;
              next_pc_value    = stack_top_entry;
              next_stack_pop   = 1'b1;
              next_fetch_flush = 1'b1;
              next_busy        = 1'b1;
              next_state       = rrx_pkg::RRX_ST_FLUSH;
            end
            rrx_pkg::RRX_OP_RETURN: begin
              next_pc_load     = 1'b1;
              next_pc_value    = stack_top_entry;
              next_stack_pop   = 1'b1;
              next_fetch_flush = 1'b1;
              next_busy        = 1'b1;
              next_state       = rrx_pkg::RRX_ST_FLUSH;
            end
            rrx_pkg::RRX_OP_ROTATE: begin
              next_carry_we  = 1'b1;
              next_carry_out = file_rdata[0];
              if (dest_file) begin
                next_file_we    = 1'b1;
                next_file_waddr = file_addr;
                next_file_wdata = rot_res;
              end else begin
                next_acc_we    = 1'b1;
                next_acc_wdata = rot_res;
              end
            end
            rrx_pkg::RRX_OP_NONE: begin
            end
          endcase
        end
      end
      rrx_pkg::RRX_ST_FLUSH: begin
        next_state = rrx_pkg::RRX_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= rrx_pkg::RRX_ST_EXEC;
      acc_we      <= 1'b0;
      acc_wdata   <= 8'h00;
      file_we     <= 1'b0;
      file_waddr  <= 7'h00;
      file_wdata  <= 8'h00;
      carry_we    <= 1'b0;
      carry_out   <= 1'b0;
      pc_load     <= 1'b0;
      pc_value    <= '0;
      stack_pop   <= 1'b0;
      fetch_flush <= 1'b0;
      busy        <= 1'b0;
    end else begin
      state       <= next_state;
      acc_we      <= next_acc_we;
      acc_wdata   <= next_acc_wdata;
      file_we     <= next_file_we;
      file_waddr  <= next_file_waddr;
      file_wdata  <= next_file_wdata;
      carry_we    <= next_carry_we;
      carry_out   <= next_carry_out;
      pc_load     <= next_pc_load;
      pc_value    <= next_pc_value;
      stack_pop   <= next_stack_pop;
      fetch_flush <= next_fetch_flush;
      busy        <= next_busy;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // a request counts only when the block is free to take it
  wire logic go = insn_valid && state == rrx_pkg::RRX_ST_EXEC;
  wire logic any_strobe = acc_we || file_we || carry_we || pc_load ||
                          stack_pop || fetch_flush || busy;

  a_litret_acc_value: assert property (
    go && op == rrx_pkg::RRX_OP_LITRET
    |=> acc_we && acc_wdata == $past(insn[`RRX_LIT_MSB:0]))
    else $error("literal not placed in accumulator");

  a_litret_pc_load: assert property (
    go && op == rrx_pkg::RRX_OP_LITRET
    |=> pc_load && stack_pop && pc_value == $past(stack_top_entry))
    else $error("literal return did not load pc");

  a_litret_two_cyc: assert property (
    go && op == rrx_pkg::RRX_OP_LITRET
    |=> !carry_we ##1 (!busy && !pc_load))
    else $error("literal return timing or flags wrong");

  a_return_pop_pc: assert property (
    go && op == rrx_pkg::RRX_OP_RETURN
    |=> stack_pop && pc_load && !carry_we && !acc_we
        && pc_value == $past(stack_top_entry))
    else $error("return did not pop into pc");

  a_return_flush_gap: assert property (
    go && (op == rrx_pkg::RRX_OP_LITRET || op == rrx_pkg::RRX_OP_RETURN)
    |=> fetch_flush ##1 !fetch_flush)
    else $error("return second cycle missing");

  // the fetch after a return is stale, so nothing may come of it
  a_flush_drop_req: assert property (
    state == rrx_pkg::RRX_ST_FLUSH |=> !any_strobe)
    else $error("request taken in the flush cycle");

  a_rotate_carry: assert property (
    go && op == rrx_pkg::RRX_OP_ROTATE
    |=> carry_we && carry_out == $past(file_rdata[0]) && !busy)
    else $error("rotate carry wrong");

  a_rotate_to_acc: assert property (
    go && op == rrx_pkg::RRX_OP_ROTATE && !dest_file
    |=> acc_we && !file_we
        && acc_wdata == {$past(carry_in), $past(file_rdata[7:1])})
    else $error("rotate to accumulator wrong");

  a_rotate_to_file: assert property (
    go && op == rrx_pkg::RRX_OP_ROTATE && dest_file
    |=> file_we && !acc_we && file_waddr == $past(insn[`RRX_ADDR_MSB:0]))
    else $error("rotate to file wrong");

  a_rotate_file_data: assert property (
    go && op == rrx_pkg::RRX_OP_ROTATE && dest_file
    |=> file_wdata == {$past(carry_in), $past(file_rdata[7:1])} && !busy)
    else $error("rotate result to file wrong");

  // judged from the raw word so a broken classifier cannot hide here
  a_rotate_decode: assert property (
    go && (insn & `RRX_ROT_MASK) == `RRX_ROT_MATCH |=> carry_we)
    else $error("rotate opcode not recognised");

  a_unknown_idle: assert property (
    go && op == rrx_pkg::RRX_OP_NONE |=> !any_strobe)
    else $error("unknown opcode produced a strobe");

  // scenarios the bench is expected to reach
  c_litret: cover property (go && op == rrx_pkg::RRX_OP_LITRET);
  c_return: cover property (go && op == rrx_pkg::RRX_OP_RETURN);
  c_rot_file: cover property (go && op == rrx_pkg::RRX_OP_ROTATE && dest_file);
  c_rot_acc: cover property (go && op == rrx_pkg::RRX_OP_ROTATE && !dest_file);
  c_flush_drop: cover property (insn_valid && state == rrx_pkg::RRX_ST_FLUSH);
endmodule
`default_nettype wire

// ==== testbench/return_and_rotate_exec_test.sv ====
// self-checking bench for the return and rotate execution block
`timescale 1ns/1ps
`default_nettype none
module return_and_rotate_exec_test;
  typedef struct {
    logic [13:0] insn;
    logic [7:0]  fr;
    logic        c;
    logic [6:0]  st;
    logic [7:0]  dat;
    logic        co;
  } rrx_row_t;
  logic        mclk, sys_rst, insn_valid, carry_in;
  logic [13:0] insn;
  logic [12:0] stk, pc_value;
  logic [7:0]  file_rdata, acc_wdata, file_wdata;
  logic [6:0]  file_waddr, stb;
  logic        acc_we, file_we, carry_we, carry_out;
  logic        pc_load, stack_pop, fetch_flush, busy;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // strobe order: acc, file, carry, pc, pop, flush, busy
  rrx_row_t    hand;
  rrx_row_t    rows [10] = '{
    '{14'h34A5, 8'h00, 1'b0, 7'b1001111, 8'hA5, 1'b0},
    '{14'h37FF, 8'h00, 1'b1, 7'b1001111, 8'hFF, 1'b0},
    '{14'h3400, 8'hFF, 1'b0, 7'b1001111, 8'h00, 1'b0},
    '{14'h0008, 8'h00, 1'b0, 7'b0001111, 8'h00, 1'b0},
    '{14'h0C05, 8'hE6, 1'b0, 7'b1010000, 8'h73, 1'b0},
    '{14'h0C85, 8'h01, 1'b1, 7'b0110000, 8'h80, 1'b1},
    '{14'h0CFF, 8'hAA, 1'b1, 7'b0110000, 8'hD5, 1'b0},
    '{14'h0009, 8'h00, 1'b0, 7'b0000000, 8'h00, 1'b0},
    '{14'h0D85, 8'h01, 1'b1, 7'b0000000, 8'h00, 1'b0},
    '{14'h3800, 8'h00, 1'b0, 7'b0000000, 8'h00, 1'b0}};
  assign stb = {acc_we, file_we, carry_we, pc_load, stack_pop, fetch_flush,
                busy};
  rrx_exec #(.PC_W(13)) i_rrx_exec (.mclk(mclk), .sys_rst(sys_rst),
    .insn_valid(insn_valid), .insn(insn), .stack_top_entry(stk),
    .file_rdata(file_rdata), .carry_in(carry_in), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .carry_we(carry_we), .carry_out(carry_out),
    .pc_load(pc_load), .pc_value(pc_value), .stack_pop(stack_pop),
    .fetch_flush(fetch_flush), .busy(busy));
  // ----------------------------------------
  // clock, timeout and reporting
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a hang here means a stuck handshake, not a slow design
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 500) begin
      failures++;
      end_of_test();
    end
  end
  // drives just after an edge; valid stays up between back-to-back issues
  task automatic issue(input logic [13:0] w, input logic [7:0] f,
                       input logic c);
    @(posedge mclk);
    insn_valid <= 1'b1;
    insn       <= w;
    file_rdata <= f;
    carry_in   <= c;
  endtask
  // the last request is taken at this edge, its answer shows right after
  task automatic idle;
    @(posedge mclk);
    insn_valid <= 1'b0;
  endtask
  task automatic chk_row(input rrx_row_t r);
    chk("strobes", 16'(stb), 16'(r.st));
    if (r.st[6]) begin
      chk("acc_wdata", 16'(acc_wdata), 16'(r.dat));
    end
    if (r.st[5]) begin
      chk("file_wdata", 16'(file_wdata), 16'(r.dat));
      chk("file_waddr", 16'(file_waddr), 16'(r.insn[6:0]));
    end
    if (r.st[4]) begin
      chk("carry_out", 16'(carry_out), 16'(r.co));
    end
    if (r.st[3]) begin
      chk("pc_value", 16'(pc_value), 16'(stk));
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    insn_valid = 1'b0;
    insn = 14'h0000;
    file_rdata = 8'h00;
    carry_in = 1'b0;
    stk = 13'h1ABC;
    repeat (12) @(posedge mclk);
    #1 chk("reset strobes", 16'(stb), 16'h0000);
    @(posedge mclk) sys_rst <= 1'b0;
    foreach (rows[i]) begin
      issue(rows[i].insn, rows[i].fr, rows[i].c);
      idle();
      #1 chk_row(rows[i]);
    end
    // back-to-back rotates, the second reads its own carry input
    issue(14'h0C85, 8'h02, 1'b0);
    issue(14'h0C01, 8'h81, 1'b1);
    hand = '{14'h0C85, 8'h02, 1'b0, 7'b0110000, 8'h01, 1'b0};
    #1 chk_row(hand);
    idle();
    hand = '{14'h0C01, 8'h81, 1'b1, 7'b1010000, 8'hC0, 1'b1};
    #1 chk_row(hand);
    // a request in the dead cycle after a literal return must be dropped
    issue(14'h3412, 8'h00, 1'b0);
    stk <= 13'h0F0F;
    issue(14'h0C85, 8'h01, 1'b1);
    hand = '{14'h3412, 8'h00, 1'b0, 7'b1001111, 8'h12, 1'b0};
    #1 chk_row(hand);
    idle();
    #1 chk("dead cycle", 16'(stb), 16'h0000);
    // asynchronous reset in mid-run clears the strobes of a taken return
    issue(14'h0008, 8'h00, 1'b0);
    idle();
    #1 chk_row(rows[3]);
    sys_rst = 1'b1;
    #1 chk("mid reset", 16'(stb), 16'h0000);
    @(posedge mclk) sys_rst <= 1'b0;
    issue(rows[5].insn, rows[5].fr, rows[5].c);
    idle();
    #1 chk_row(rows[5]);
    end_of_test();
  end
endmodule
`default_nettype wire
